/* File: verilog/tac_tx_ctrl.sv */
// transmit alarm, interrupt and clock multiplier control register group
module tac_tx_ctrl import tac_pkg::*; #(
	parameter int CAL_COUNT = CAL_CYCLES,
	parameter int RESET_COUNT = SW_RESET_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic ref_clock_coarse_deviation,
	input wire logic tx_signal_loss,
	input wire logic tx_lock_loss,
	input wire logic tx_fifo_overflow,
	input wire logic tx_fifo_underflow,
	input wire logic pattern_error_alarm,
	input wire logic pattern_sync_loss_alarm,
	input wire logic signal_quality_alarm,
	input wire logic global_interrupt_enable,
	input wire logic fifo_auto_clear_option,
	input wire logic ref_clock_present,
	output logic interrupt_out,
	output logic [3:0] jitter_bandwidth_select,
	output logic [2:0] timing_mode_select,
	output logic bandwidth_unsupported,
	output logic lock_to_reference,
	output logic keep_data_lock_option,
	output logic lock_loss_method,
	output logic [1:0] oscillator_cal_mode,
	output logic vco_full_sweep,
	output logic oscillator_cal_invalid,
	output logic calibration_active,
	output logic tx_soft_reset
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic method_of(input logic [7:0] lock, input logic [2:0] mode);
		if (lock[OVERRIDE_BIT])
			return lock[METHOD_BIT];
		return (mode == MODE_REFLESS);
	endfunction

	function automatic logic bw_bad(input logic [3:0] bw, input logic [2:0] mode);
		logic ok;
		ok = 1'b0;
		case (bw)
			BW_180_HZ, BW_1370_HZ: ok = (mode == MODE_ASYNC_REF) || (mode == MODE_LOOP_TIMED);
			BW_380_KHZ: ok = (mode == MODE_REFLESS) || (mode == MODE_SYNC_REF);
			default: ok = 1'b0;
		endcase
		return !ok;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [ALARM_W-1:0] mask;
	logic [ALARM_W-1:0] latched;
	logic [ALARM_W-1:0] live;
	logic [7:0] cmu_cfg;
	logic [7:0] lock_cfg;
	logic [7:0] cal_cfg;
	logic enable_seen;
	logic cal_busy;
	logic cal_done;
	logic rst_busy;
	logic rst_done;
	logic [7:0] read_value;
	logic [ALARM_W-1:0] next_latched;

	logic wr_mask;
	logic wr_latched;
	logic wr_cmu;
	logic wr_lock;
	logic wr_cal;
	logic soft_reset_start;
	logic mode_change;
	logic force_start;
	logic cal_start;

	assign wr_mask = reg_write && (reg_addr == ADDR_MASK);
	assign wr_latched = reg_write && (reg_addr == ADDR_LATCHED);
	assign wr_cmu = reg_write && (reg_addr == ADDR_CMU);
	assign wr_lock = reg_write && (reg_addr == ADDR_LOCK);
	assign wr_cal = reg_write && (reg_addr == ADDR_CAL);
	assign soft_reset_start = wr_cal && reg_wdata[SW_RESET_BIT];
	assign mode_change = wr_cmu && !soft_reset_start
		&& (reg_wdata[MODE_MSB:MODE_LSB] != cmu_cfg[MODE_MSB:MODE_LSB]);
	assign force_start = wr_cal && !soft_reset_start && reg_wdata[FORCE_CAL_BIT];
	assign cal_start = mode_change || force_start;

	// ----------------------------------------
	// timers
	// ----------------------------------------
	tac_cycle_timer #(.CYCLES(CAL_COUNT)) u_cal_timer (
		.clock(clock),
		.rst_n(rst_n),
		.start(cal_start),
		.busy(cal_busy),
		.done(cal_done)
	);

	tac_cycle_timer #(.CYCLES(RESET_COUNT)) u_reset_timer (
		.clock(clock),
		.rst_n(rst_n),
		.start(soft_reset_start),
		.busy(rst_busy),
		.done(rst_done)
	);

	// ----------------------------------------
	// live alarms
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			live <= RST_LIVE[ALARM_W-1:0];
		end else begin
			live[BIT_REF_LOSS] <= ref_clock_coarse_deviation;
			live[BIT_SIGNAL_LOSS] <= tx_signal_loss;
			live[BIT_LOCK_LOSS] <= tx_lock_loss;
			live[BIT_FIFO_ERR] <= tx_fifo_overflow || tx_fifo_underflow;
			live[BIT_PATTERN_ERR] <= pattern_error_alarm;
			live[BIT_PATTERN_SYNC] <= pattern_sync_loss_alarm;
			live[BIT_SQM] <= signal_quality_alarm;
		end
	end

	// ----------------------------------------
	// latched status, set wins over clear
	// ----------------------------------------
	always_comb begin
		next_latched = latched;
		if (soft_reset_start || (enable_seen && !global_interrupt_enable))
			next_latched = '0;
		else if (wr_latched)
			next_latched = latched & reg_wdata[ALARM_W-1:0];
		next_latched = next_latched | live;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			latched <= RST_LATCHED[ALARM_W-1:0];
			enable_seen <= 1'b0;
		end else begin
			latched <= next_latched;
			enable_seen <= global_interrupt_enable;
		end
	end

	// ----------------------------------------
	// writable configuration
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask <= RST_MASK[ALARM_W-1:0];
			cmu_cfg <= RST_CMU;
			lock_cfg <= RST_LOCK;
		end else if (soft_reset_start) begin
			mask <= RST_MASK[ALARM_W-1:0];
			cmu_cfg <= RST_CMU;
			lock_cfg <= RST_LOCK;
		end else begin
			if (wr_mask)
				mask <= reg_wdata[ALARM_W-1:0];
			if (wr_cmu) begin
				cmu_cfg[BW_MSB:BW_LSB] <= reg_wdata[BW_MSB:BW_LSB];
				cmu_cfg[MODE_MSB:MODE_LSB] <= reg_wdata[MODE_MSB:MODE_LSB];
			end
			if (wr_lock) begin
				lock_cfg[LOCK_RSV_MSB:LOCK_RSV_LSB] <= reg_wdata[LOCK_RSV_MSB:LOCK_RSV_LSB];
				lock_cfg[KEEP_DATA_BIT] <= reg_wdata[KEEP_DATA_BIT];
				lock_cfg[OVERRIDE_BIT] <= reg_wdata[OVERRIDE_BIT];
				lock_cfg[METHOD_BIT] <= reg_wdata[METHOD_BIT];
				lock_cfg[LTR_BIT] <= reg_wdata[LTR_BIT];
			end
		end
	end

	// ----------------------------------------
	// calibration control, self clearing bits
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cal_cfg <= RST_CAL;
		end else if (soft_reset_start) begin
			cal_cfg <= RST_CAL;
			cal_cfg[SW_RESET_BIT] <= 1'b1;
		end else begin
			if (rst_done)
				cal_cfg[SW_RESET_BIT] <= 1'b0;
			if (wr_cal)
				cal_cfg[OSC_MSB:OSC_LSB] <= reg_wdata[OSC_MSB:OSC_LSB];
			if (force_start)
				cal_cfg[FORCE_CAL_BIT] <= 1'b1;
			else if (cal_done)
				cal_cfg[FORCE_CAL_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_comb begin
		read_value = 8'h00;
		case (reg_addr)
			ADDR_MASK: begin
				read_value = {1'b0, mask};
				if (fifo_auto_clear_option)
					read_value[BIT_FIFO_ERR] = 1'b0;
			end
			ADDR_LATCHED: read_value = {1'b0, latched};
			ADDR_CMU: begin
				read_value[BW_MSB:BW_LSB] = cmu_cfg[BW_MSB:BW_LSB];
				read_value[MODE_MSB:MODE_LSB] = cmu_cfg[MODE_MSB:MODE_LSB];
			end
			ADDR_LOCK: begin
				read_value = lock_cfg;
				read_value[0] = 1'b0;
				read_value[METHOD_BIT] = method_of(lock_cfg, cmu_cfg[MODE_MSB:MODE_LSB]);
			end
			ADDR_CAL: read_value = {4'h0, cal_cfg[3:0]};
			ADDR_LIVE: read_value = {1'b0, live};
			default: read_value = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			if (reg_read)
				reg_rdata <= read_value;
		end
	end

	// ----------------------------------------
	// interrupt and control outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out <= 1'b0;
		end else begin
			interrupt_out <= global_interrupt_enable && |(latched & ~mask);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			jitter_bandwidth_select <= RST_CMU[BW_MSB:BW_LSB];
			timing_mode_select <= RST_CMU[MODE_MSB:MODE_LSB];
			bandwidth_unsupported <= 1'b0;
			lock_to_reference <= 1'b0;
			keep_data_lock_option <= 1'b0;
			lock_loss_method <= 1'b0;
			oscillator_cal_mode <= OSC_AUTO;
			vco_full_sweep <= 1'b0;
			oscillator_cal_invalid <= 1'b0;
			calibration_active <= 1'b0;
			tx_soft_reset <= 1'b0;
		end else begin
			jitter_bandwidth_select <= cmu_cfg[BW_MSB:BW_LSB];
			timing_mode_select <= cmu_cfg[MODE_MSB:MODE_LSB];
			bandwidth_unsupported <= bw_bad(cmu_cfg[BW_MSB:BW_LSB],
				cmu_cfg[MODE_MSB:MODE_LSB]);
			lock_to_reference <= lock_cfg[LTR_BIT]
				|| (cmu_cfg[MODE_MSB:MODE_LSB] == MODE_SYNC_REF);
			keep_data_lock_option <= lock_cfg[KEEP_DATA_BIT];
			lock_loss_method <= method_of(lock_cfg, cmu_cfg[MODE_MSB:MODE_LSB]);
			oscillator_cal_mode <= cal_cfg[OSC_MSB:OSC_LSB];
			vco_full_sweep <= (cal_cfg[OSC_MSB:OSC_LSB] == OSC_SWEEP)
				|| ((cal_cfg[OSC_MSB:OSC_LSB] == OSC_AUTO) && !ref_clock_present);
			oscillator_cal_invalid <= (cal_cfg[OSC_MSB:OSC_LSB] == OSC_INVALID);
			calibration_active <= cal_busy || cal_start;
			tx_soft_reset <= rst_busy || soft_reset_start;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_irq_from_latch: assert property (
		(global_interrupt_enable && |(latched & ~mask)) |=> interrupt_out)
		else $error("interrupt missing for unmasked latched alarm");
	a_masked_no_irq: assert property (
		((latched & ~mask) == '0) |=> !interrupt_out)
		else $error("interrupt raised with every latched alarm masked");
	a_latch_catches: assert property (
		live[BIT_LOCK_LOSS] |=> latched[BIT_LOCK_LOSS] ##1 (latched[BIT_LOCK_LOSS]
		|| $past(soft_reset_start) || $past(wr_latched) || !$past(global_interrupt_enable)))
		else $error("live alarm not latched and held");
	a_zero_write_clears: assert property (
		(wr_latched && reg_wdata == 8'h00 && live == '0) |=> latched == '0)
		else $error("written zero did not clear latched status");
	a_one_write_keeps: assert property (
		(wr_latched && !soft_reset_start && !(enable_seen && !global_interrupt_enable))
		|=> ((latched & $past(latched) & $past(reg_wdata[ALARM_W-1:0]))
		== ($past(latched) & $past(reg_wdata[ALARM_W-1:0]))))
		else $error("written one changed latched bit");
	a_fifo_mask_hidden: assert property (
		(reg_read && reg_addr == ADDR_MASK && fifo_auto_clear_option)
		|=> reg_rvalid && !reg_rdata[BIT_FIFO_ERR] && !reg_rdata[7])
		else $error("fifo error mask bit visible under auto clear");
	a_live_readback: assert property (
		(reg_read && reg_addr == ADDR_LIVE) |=> reg_rdata == {1'b0, $past(live)})
		else $error("live status readback wrong");
	a_sync_mode_ltr: assert property (
		(cmu_cfg[MODE_MSB:MODE_LSB] == MODE_SYNC_REF) |=> lock_to_reference)
		else $error("sync reference mode did not lock to reference");
	a_mode_recal: assert property (
		mode_change |=> calibration_active [*2])
		else $error("timing mode change did not start recalibration");
	a_force_self_clear: assert property (
		(cal_cfg[FORCE_CAL_BIT] && cal_done && !force_start) |=> !cal_cfg[FORCE_CAL_BIT])
		else $error("force recalibration bit not cleared on completion");
	a_software_reset_bit_defaults: assert property (
		soft_reset_start |=> cmu_cfg == RST_CMU && lock_cfg == RST_LOCK
		&& latched == $past(live) && cal_cfg[SW_RESET_BIT] && tx_soft_reset)
		else $error("software reset did not restore defaults");
	a_auto_method: assert property (
		(!lock_cfg[OVERRIDE_BIT] && cmu_cfg[MODE_MSB:MODE_LSB] == MODE_REFLESS)
		|=> lock_loss_method)
		else $error("auto lock loss method wrong for referenceless mode");
	a_osc_invalid: assert property (
		(cal_cfg[OSC_MSB:OSC_LSB] == OSC_INVALID) |=> oscillator_cal_invalid)
		else $error("invalid oscillator cal mode not flagged");

	c_interrupt: cover property (global_interrupt_enable ##1 interrupt_out);
	c_soft_reset: cover property (soft_reset_start ##1 tx_soft_reset);
	c_cal_done: cover property (cal_busy ##1 cal_done);
	c_disable_clear: cover property ((latched != '0) && enable_seen && !global_interrupt_enable);

endmodule // tac_tx_ctrl

/* File: common/tac_pkg.sv */
// register map, field layout, reset values and timing counts of the transmit control group
package tac_pkg;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_MASK = 8'h84;
	localparam logic [7:0] ADDR_LATCHED = 8'h85;
	localparam logic [7:0] ADDR_CMU = 8'h86;
	localparam logic [7:0] ADDR_LOCK = 8'h87;
	localparam logic [7:0] ADDR_CAL = 8'h88;
	localparam logic [7:0] ADDR_LIVE = 8'h89;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_LATCHED = 8'h00;
	localparam logic [7:0] RST_CMU = 8'h40;
	localparam logic [7:0] RST_LOCK = 8'h94;
	localparam logic [7:0] RST_CAL = 8'h00;
	localparam logic [7:0] RST_LIVE = 8'h00;

	// ----------------------------------------
	// alarm layout shared by mask, latched and live
	// ----------------------------------------
	localparam int ALARM_W = 7;
	localparam int BIT_REF_LOSS = 6;
	localparam int BIT_SIGNAL_LOSS = 5;
	localparam int BIT_LOCK_LOSS = 4;
	localparam int BIT_FIFO_ERR = 3;
	localparam int BIT_PATTERN_ERR = 2;
	localparam int BIT_PATTERN_SYNC = 1;
	localparam int BIT_SQM = 0;

	// ----------------------------------------
	// clock multiplier config fields
	// ----------------------------------------
	localparam int BW_MSB = 7;
	localparam int BW_LSB = 4;
	localparam int MODE_MSB = 2;
	localparam int MODE_LSB = 0;
	localparam logic [3:0] BW_180_HZ = 4'h0;
	localparam logic [3:0] BW_1370_HZ = 4'h1;
	localparam logic [3:0] BW_380_KHZ = 4'h4;
	localparam logic [2:0] MODE_REFLESS = 3'h0;
	localparam logic [2:0] MODE_SYNC_REF = 3'h1;
	localparam logic [2:0] MODE_ASYNC_REF = 3'h2;
	localparam logic [2:0] MODE_LOOP_TIMED = 3'h6;

	// ----------------------------------------
	// lock config fields
	// ----------------------------------------
	localparam int LOCK_RSV_MSB = 7;
	localparam int LOCK_RSV_LSB = 5;
	localparam int KEEP_DATA_BIT = 4;
	localparam int OVERRIDE_BIT = 3;
	localparam int METHOD_BIT = 2;
	localparam int LTR_BIT = 1;

	// ----------------------------------------
	// calibration control fields
	// ----------------------------------------
	localparam int FORCE_CAL_BIT = 3;
	localparam int OSC_MSB = 2;
	localparam int OSC_LSB = 1;
	localparam int SW_RESET_BIT = 0;
	localparam logic [1:0] OSC_AUTO = 2'h0;
	localparam logic [1:0] OSC_SWEEP = 2'h1;
	localparam logic [1:0] OSC_REF = 2'h2;
	localparam logic [1:0] OSC_INVALID = 2'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int CAL_TIME_NS = 100000;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SW_RESET_TIME_NS = 1000;
	localparam int SW_RESET_CYCLES = (SW_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

/* File: verilog/tac_cycle_timer.sv */
// one-shot cycle timer with busy level and done pulse
module tac_cycle_timer import tac_pkg::*; #(
	parameter int CYCLES = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	output logic busy,
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef enum {TMR_IDLE, TMR_RUN} tac_timer_state_type;

	tac_timer_state_type state;
	logic [CW-1:0] count;

	// ----------------------------------------
	// sequencing, a new start restarts the count
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= TMR_IDLE;
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				state <= TMR_RUN;
				count <= LAST;
				busy <= 1'b1;
			end else begin
				case (state)
					TMR_IDLE: begin
						busy <= 1'b0;
					end
					TMR_RUN: begin
						if (count == '0) begin
							state <= TMR_IDLE;
							busy <= 1'b0;
							done <= 1'b1;
						end else begin
							count <= count - 1'b1;
						end
					end
					default: begin
						state <= TMR_IDLE;
						busy <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule // tac_cycle_timer

/* File: verification/tac_host_model.sv */
// host side model driving the register strobe port
module tac_host_model (
	input wire logic clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// one-cycle write strobe; never aimed at 0xcd or 0xe2
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		#1;
		reg_addr = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask

	// one-cycle read strobe
	task automatic rd(input logic [7:0] addr);
		@(posedge clock);
		#1;
		reg_addr = addr;
		reg_read = 1'b1;
		@(posedge clock);
		#1;
		reg_read = 1'b0;
		reg_addr = ~addr;
	endtask
endmodule // tac_host_model

/* File: verification/tac_tx_ctrl_tb.sv */
// self-checking bench of the transmit control register group
module tac_tx_ctrl_tb import tac_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CAL_N = 8;
	localparam int SWR_N = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_write, reg_read, reg_rvalid;
	// alarm_in bit 7 steers the fifo error to underflow
	logic [7:0] alarm_in = 8'h00;
	logic glb_en = 1'b1;
	logic auto_clr = 1'b0;
	logic ref_present = 1'b0;
	logic interrupt_out, bandwidth_unsupported, lock_to_reference, keep_data_lock_option;
	logic lock_loss_method, vco_full_sweep, oscillator_cal_invalid, calibration_active;
	logic tx_soft_reset;
	logic [3:0] jitter_bandwidth_select;
	logic [2:0] timing_mode_select;
	logic [1:0] oscillator_cal_mode;
	logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h6, 3'h0};
	logic [7:0] exp_q[$];
	logic [7:0] r = 8'h4a;
	int error_cnt = 0;
	int checks = 0;

	always #20 clock = ~clock;

	tac_host_model host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read);

	tac_tx_ctrl #(.CAL_COUNT(CAL_N), .RESET_COUNT(SWR_N)) DUT (
		.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
		.ref_clock_coarse_deviation(alarm_in[6]), .tx_signal_loss(alarm_in[5]),
		.tx_lock_loss(alarm_in[4]), .tx_fifo_overflow(alarm_in[3] & ~alarm_in[7]),
		.tx_fifo_underflow(alarm_in[3] & alarm_in[7]), .pattern_error_alarm(alarm_in[2]),
		.pattern_sync_loss_alarm(alarm_in[1]), .signal_quality_alarm(alarm_in[0]),
		.global_interrupt_enable(glb_en), .fifo_auto_clear_option(auto_clr),
		.ref_clock_present(ref_present), .interrupt_out, .jitter_bandwidth_select,
		.timing_mode_select, .bandwidth_unsupported, .lock_to_reference, .keep_data_lock_option,
		.lock_loss_method, .oscillator_cal_mode, .vco_full_sweep, .oscillator_cal_invalid,
		.calibration_active, .tx_soft_reset
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] want);
		exp_q.push_back(want);
		host.rd(addr);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic note(input string s);
		$display("test %s finished", s);
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// read answers against the oldest expectation
	always @(negedge clock) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() > 0)
				chk(reg_rdata, exp_q.pop_front());
			else
				chk(8'h00, 8'hff);
		end
	end

	initial begin
		#(40 * 3000);
		error_cnt++;
		close_out();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(12);
		rst_n = 1'b1;
		chk(8'(jitter_bandwidth_select), 8'h04);
		chk(8'(interrupt_out), 8'h00);
		rd(ADDR_MASK, 8'h00);
		rd(ADDR_LATCHED, 8'h00);
		rd(ADDR_CMU, 8'h40);
		rd(ADDR_LOCK, 8'h94);
		rd(ADDR_CAL, 8'h00);
		host.wr(ADDR_LIVE, 8'h7f);
		rd(ADDR_LIVE, 8'h00);
		rd(8'h8a, 8'h00);
		note("reset");
		for (int i = 0; i < 4; i++) begin
			r = lfsr(r);
			alarm_in = r;
			tick(4);
			chk(8'(interrupt_out), 8'(r[6:0] != 7'h00));
			rd(ADDR_LIVE, {1'b0, r[6:0]});
			alarm_in = 8'h00;
			tick(3);
			rd(ADDR_LATCHED, {1'b0, r[6:0]});
			host.wr(ADDR_LATCHED, 8'hff);
			rd(ADDR_LATCHED, {1'b0, r[6:0]});
			host.wr(ADDR_LATCHED, {1'b0, r[6:0]} & 8'h55);
			rd(ADDR_LATCHED, {1'b0, r[6:0]} & 8'h55);
			host.wr(ADDR_LATCHED, 8'h00);
			tick(3);
			chk(8'(interrupt_out), 8'h00);
		end
		note("alarms");
		host.wr(ADDR_MASK, 8'hff);
		rd(ADDR_MASK, 8'h7f);
		alarm_in = 8'h50;
		tick(4);
		chk(8'(interrupt_out), 8'h00);
		host.wr(ADDR_MASK, 8'h6f);
		tick(2);
		chk(8'(interrupt_out), 8'h01);
		auto_clr = 1'b1;
		rd(ADDR_MASK, 8'h67);
		auto_clr = 1'b0;
		rd(ADDR_MASK, 8'h6f);
		alarm_in = 8'h00;
		tick(3);
		glb_en = 1'b0;
		tick(2);
		chk(8'(interrupt_out), 8'h00);
		glb_en = 1'b1;
		rd(ADDR_LATCHED, 8'h00);
		host.wr(ADDR_MASK, 8'h00);
		note("mask");
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR_CMU, {5'h08, modes[i]});
			tick(1);
			chk(8'(calibration_active), 8'h01);
			tick(1);
			chk(8'(timing_mode_select), 8'(modes[i]));
			chk(8'(lock_to_reference), 8'(modes[i] == 3'h1));
			chk(8'(bandwidth_unsupported), 8'(modes[i][1]));
			chk(8'(lock_loss_method), 8'(modes[i] == 3'h0));
			rd(ADDR_LOCK, {5'h12, modes[i] == 3'h0, 2'h0});
		end
		note("modes");
		host.wr(ADDR_CMU, 8'h12);
		host.wr(ADDR_CAL, 8'h08);
		tick(1);
		chk(8'(calibration_active), 8'h01);
		chk(8'(bandwidth_unsupported), 8'h00);
		chk(8'(jitter_bandwidth_select), 8'h01);
		rd(ADDR_CAL, 8'h08);
		tick(CAL_N + 4);
		chk(8'(calibration_active), 8'h00);
		rd(ADDR_CAL, 8'h00);
		rd(ADDR_CMU, 8'h12);
		note("recal");
		host.wr(ADDR_LOCK, 8'h9f);
		tick(2);
		chk(8'(keep_data_lock_option), 8'h01);
		chk(8'(lock_to_reference), 8'h01);
		chk(8'(lock_loss_method), 8'h01);
		rd(ADDR_LOCK, 8'h9e);
		host.wr(ADDR_LOCK, 8'h88);
		tick(2);
		chk(8'(lock_loss_method), 8'h00);
		chk(8'(lock_to_reference), 8'h00);
		chk(8'(keep_data_lock_option), 8'h00);
		note("lock");
		for (int c = 0; c < 4; c++) begin
			r = lfsr(r);
			ref_present = r[0];
			host.wr(ADDR_CAL, {5'h00, 2'(c), 1'b0});
			tick(2);
			chk(8'(oscillator_cal_mode), 8'(c));
			chk(8'(vco_full_sweep), 8'(c == 1 || (c == 0 && !r[0])));
			chk(8'(oscillator_cal_invalid), 8'(c == 3));
		end
		ref_present = 1'b0;
		host.wr(ADDR_CAL, 8'h00);
		tick(2);
		chk(8'(vco_full_sweep), 8'h01);
		note("oscillator");
		host.wr(ADDR_MASK, 8'h55);
		host.wr(ADDR_CAL, 8'h01);
		tick(1);
		chk(8'(tx_soft_reset), 8'h01);
		rd(ADDR_CAL, 8'h01);
		tick(SWR_N + 4);
		chk(8'(tx_soft_reset), 8'h00);
		rd(ADDR_CAL, 8'h00);
		rd(ADDR_MASK, 8'h00);
		rd(ADDR_LOCK, 8'h94);
		rd(ADDR_CMU, 8'h40);
		note("soft reset");
		tick(3);
		chk(8'(exp_q.size()), 8'h00);
		close_out();
	end
endmodule // tac_tx_ctrl_tb
